/* shared/djkff_defines.svh */
// constants for the dual jk storage block
`ifndef DJKFF_DEFINES_SVH
`define DJKFF_DEFINES_SVH

// stored state after the block reset
`define DJKFF_RST_Q        1'b0
// sampled level of the edge clock after reset, low so release makes no edge
`define DJKFF_RST_CLK_PREV 1'b0
// sampled j and k after reset
`define DJKFF_RST_JK       1'b0
// value a forced element holds while preset and clear are both low
`define DJKFF_BOTH_LOW_Q   1'b1
// number of storage elements
`define DJKFF_NUM_ELEM     2

`endif

/* shared/djkff_pkg.sv */
// types for the dual jk storage block
package djkff_pkg;

  // what one element does at a falling edge
  typedef enum logic [1:0]
  {
    DJKFF_HOLD,
    DJKFF_RESET,
    DJKFF_SET,
    DJKFF_TOGGLE
  } djkff_action_t;

  // state of one element
  typedef struct packed
  {
    logic q; // stored true value
  } djkff_elem_st_t;

  // state of the shared front end
  typedef struct packed
  {
    logic       clk_prev; // edge clock level seen one cycle ago
    logic [1:0] j;        // j of each element, taken before the edge
    logic [1:0] k;        // k of each element, taken before the edge
  } djkff_top_st_t;

  // decode j and k into an action
  function automatic djkff_action_t djkff_decode(input logic j, input logic k);
    djkff_action_t act;
    act = DJKFF_HOLD;
    unique case ({j, k})
      2'b00: act = DJKFF_HOLD;
      2'b01: act = DJKFF_RESET;
      2'b10: act = DJKFF_SET;
      2'b11: act = DJKFF_TOGGLE;
    endcase
    return act;
  endfunction : djkff_decode

endpackage : djkff_pkg

/* src/djkff_elem.sv */
// one jk storage element with direct preset and clear
`timescale 1ns/1ps
`include "djkff_defines.svh"

module djkff_elem
(
  input  wire logic clk,       // system clock
  input  wire logic nrst,      // async reset, active low
  input  wire logic fall_edge, // edge clock went high to low
  input  wire logic j_smp,     // j taken before the edge
  input  wire logic k_smp,     // k taken before the edge
  input  wire logic preset_n,  // direct preset, active low
  input  wire logic clear_n,   // direct clear, active low
  output logic      q,         // true output
  output logic      q_n        // complement output
);

  djkff_pkg::djkff_elem_st_t st_ff;  // registered state
  djkff_pkg::djkff_elem_st_t nxt_st; // next state

  //////////////////////////////////////////////////////////////////////////////
  // next state: direct inputs win, else act on the edge
  always_comb
  begin
    nxt_st = st_ff;
    if (!preset_n && !clear_n)
    begin
      // both low: keep a defined value
      nxt_st.q = `DJKFF_BOTH_LOW_Q;
    end
    else if (!preset_n)
    begin
      // preset blocks clocking
      nxt_st.q = 1'b1;
    end
    else if (!clear_n)
    begin
      // clear blocks clocking
      nxt_st.q = 1'b0;
    end
    else if (fall_edge)
    begin
      // only the falling edge moves the state
      unique case (djkff_pkg::djkff_decode(j_smp, k_smp))
        djkff_pkg::DJKFF_HOLD:   nxt_st.q = st_ff.q;
        djkff_pkg::DJKFF_RESET:  nxt_st.q = 1'b0;
        djkff_pkg::DJKFF_SET:    nxt_st.q = 1'b1;
        djkff_pkg::DJKFF_TOGGLE: nxt_st.q = ~st_ff.q;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      st_ff.q <= `DJKFF_RST_Q;
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // outputs: direct inputs override at once, without the clock
  always_comb
  begin
    q   = st_ff.q;
    q_n = ~st_ff.q;
    if (!preset_n)
    begin
      q = 1'b1;
    end
    else if (!clear_n)
    begin
      q = 1'b0;
    end
    if (!clear_n)
    begin
      q_n = 1'b1;
    end
    else if (!preset_n)
    begin
      q_n = 1'b0;
    end
  end

endmodule : djkff_elem

/* src/djkff_top.sv */
// dual jk storage block with shared edge clock and shared clear
//
// Operation
// - two elements share clock and clear
// - clocked state moves only on falling clock edge
// - j, k changes between edges ignored
// - j, k taken just before the edge
// - jk: hold, reset, set, toggle
// - preset forces high, clear forces low
// - preset and clear act without clock
// - both low drive both outputs high
// - each element has its own preset
// - complement inverts true output otherwise
`timescale 1ns/1ps
`include "djkff_defines.svh"

module djkff_top
(
  input  wire logic clk,                // system clock, 20 MHz
  input  wire logic nrst,               // async reset, active low
  input  wire logic falling_edge_clock, // shared edge clock, falls to act
  input  wire logic clear_n,            // shared direct clear, active low
  input  wire logic preset1_n,          // direct preset element 1, active low
  input  wire logic preset2_n,          // direct preset element 2, active low
  input  wire logic j1,                 // j of element 1
  input  wire logic k1,                 // k of element 1
  input  wire logic j2,                 // j of element 2
  input  wire logic k2,                 // k of element 2
  output logic      q1,                 // true output element 1
  output logic      q1_n,               // complement output element 1
  output logic      q2,                 // true output element 2
  output logic      q2_n                // complement output element 2
);

  djkff_pkg::djkff_top_st_t st_ff;  // registered front end
  djkff_pkg::djkff_top_st_t nxt_st; // next front end
  logic                     fall;   // falling edge seen this cycle

  //////////////////////////////////////////////////////////////////////////////
  // falling edge detect on the shared clock
  assign fall = st_ff.clk_prev & ~falling_edge_clock;

  //////////////////////////////////////////////////////////////////////////////
  // front end next state: track clock, take j and k every cycle
  always_comb
  begin
    nxt_st          = st_ff;
    nxt_st.clk_prev = falling_edge_clock;
    // values of the cycle before the edge decide the action
    nxt_st.j = {j2, j1};
    nxt_st.k = {k2, k1};
  end

  //////////////////////////////////////////////////////////////////////////////
  // front end register
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      st_ff.clk_prev <= `DJKFF_RST_CLK_PREV;
      st_ff.j        <= {`DJKFF_NUM_ELEM{`DJKFF_RST_JK}};
      st_ff.k        <= {`DJKFF_NUM_ELEM{`DJKFF_RST_JK}};
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // element 1: shared edge and clear, own preset
  djkff_elem u_elem1
  (
    .clk       (clk),
    .nrst      (nrst),
    .fall_edge (fall),
    .j_smp     (st_ff.j[0]),
    .k_smp     (st_ff.k[0]),
    .preset_n  (preset1_n),
    .clear_n   (clear_n),
    .q         (q1),
    .q_n       (q1_n)
  );

  // element 2: shared edge and clear, own preset
  djkff_elem u_elem2
  (
    .clk       (clk),
    .nrst      (nrst),
    .fall_edge (fall),
    .j_smp     (st_ff.j[1]),
    .k_smp     (st_ff.k[1]),
    .preset_n  (preset2_n),
    .clear_n   (clear_n),
    .q         (q2),
    .q_n       (q2_n)
  );

  //////////////////////////////////////////////////////////////////////////////
  // checks on the stored state and the outputs

  // toggle on a falling edge with direct inputs released
  toggle_one_a : assert property (@(posedge clk) disable iff (!nrst)
    (fall && st_ff.j[0] && st_ff.k[0] && preset1_n && clear_n) ##1
    (preset1_n && clear_n) |-> (q1 == !$past(q1)))
    else $error("element 1 did not toggle");

  // set and reset on a falling edge
  set_reset_a : assert property (@(posedge clk) disable iff (!nrst)
    (fall && (st_ff.j[1] != st_ff.k[1]) && preset2_n && clear_n) ##1
    (preset2_n && clear_n) |-> (q2 == $past(st_ff.j[1])))
    else $error("element 2 set or reset wrong");

  // hold with j and k low
  hold_jk_a : assert property (@(posedge clk) disable iff (!nrst)
    (fall && !st_ff.j[0] && !st_ff.k[0] && preset1_n && clear_n) ##1
    (preset1_n && clear_n) |-> $stable(q1))
    else $error("element 1 changed on hold");

  // no change without a falling edge
  no_edge_a : assert property (@(posedge clk) disable iff (!nrst)
    (!fall && preset1_n && clear_n && preset2_n) ##1
    (preset1_n && clear_n && preset2_n) |-> ($stable(q1) && $stable(q2)))
    else $error("state moved without a falling edge");

  // j of element 1 arriving at the edge cycle does not decide it
  late_jk_a : assert property (@(posedge clk) disable iff (!nrst)
    (fall && !st_ff.j[0] && !st_ff.k[0] && j1 && preset1_n && clear_n) ##1
    (preset1_n && clear_n) |-> (q1 == $past(q1)))
    else $error("late j was used at the edge");

  // preset forces outputs at once
  preset_force_a : assert property (@(posedge clk) disable iff (!nrst)
    (!preset1_n && clear_n) |-> (q1 && !q1_n))
    else $error("preset did not force element 1");

  // clear forces both elements at once
  clear_force_a : assert property (@(posedge clk) disable iff (!nrst)
    (!clear_n && preset1_n && preset2_n) |-> (!q1 && q1_n && !q2 && q2_n))
    else $error("clear did not force outputs");

  // both low drive both outputs high
  both_low_a : assert property (@(posedge clk) disable iff (!nrst)
    (!clear_n && !preset2_n) |-> (q2 && q2_n))
    else $error("both low did not give high outputs");

  // complement outputs track the true outputs
  compl_out_a : assert property (@(posedge clk) disable iff (!nrst)
    (clear_n && preset1_n && preset2_n) |-> ((q1_n == !q1) && (q2_n == !q2)))
    else $error("complement not inverse of true output");

  // presets stay separate per element
  own_preset_a : assert property (@(posedge clk) disable iff (!nrst)
    (!preset1_n && preset2_n && clear_n) ##1
    (preset1_n && preset2_n && clear_n) |-> $stable(q2) || $past(fall))
    else $error("preset of element 1 moved element 2");

endmodule : djkff_top

/* verif/djkff_drv.sv */
// partner model: the logic driving edge clock, jk and direct inputs
`timescale 1ns/1ps

module djkff_drv
(
  input  wire logic       clk,  // system clock
  output logic            fclk, // shared edge clock
  output logic      [2:0] dir,  // clear_n, preset1_n, preset2_n
  output logic      [3:0] jk    // j1, k1, j2, k2
);
  ////////////////////////////////////////////////////////////////////////
  // idle levels: clock low, direct inputs released, jk at hold
  initial
  begin
    fclk = 1'b0;
    dir  = 3'h7;
    jk   = 4'h0;
  end

  ////////////////////////////////////////////////////////////////////////
  // one falling edge; direct inputs stay put, so any release came
  // at least two cycles before the fall
  task automatic pulse(input logic [3:0] v, input logic late);
    @(posedge clk);
    jk   <= v;
    fclk <= 1'b1;
    @(posedge clk);
    fclk <= 1'b0;
    // late: jk flipped together with the fall, after the setup point
    if (late)
    begin
      jk <= ~v;
    end
    @(posedge clk);
    jk <= 4'h0;
  endtask : pulse

  ////////////////////////////////////////////////////////////////////////
  // set clock level and jk on one edge
  task automatic lvl(input logic c, input logic [3:0] v);
    @(posedge clk);
    fclk <= c;
    jk   <= v;
  endtask : lvl

  // set direct inputs on one edge
  task automatic set_dir(input logic [2:0] d);
    @(posedge clk);
    dir <= d;
  endtask : set_dir
endmodule : djkff_drv

/* verif/djkff_top_test.sv */
// self-checking bench for the dual jk storage block
`timescale 1ns/1ps

module djkff_top_test;
  logic       clk;         // system clock
  logic       nrst;        // async reset, active low
  logic       fclk;        // edge clock from the partner
  logic [2:0] dir;         // direct inputs from the partner
  logic [3:0] jk;          // jk from the partner
  logic       q1;          // element 1 true
  logic       q1_n;        // element 1 complement
  logic       q2;          // element 2 true
  logic       q2_n;        // element 2 complement
  logic       e1;          // expected stored value 1
  logic       e2;          // expected stored value 2
  int         err_count;   // mismatches
  int         checks_done; // comparisons

  ////////////////////////////////////////////////////////////////////////
  // 20 MHz clock
  initial clk = 1'b0;
  always #25 clk = ~clk;

  djkff_drv drv (.clk(clk), .fclk(fclk), .dir(dir), .jk(jk));

  djkff_top dut
  (
    .clk(clk), .nrst(nrst), .falling_edge_clock(fclk), .clear_n(dir[2]),
    .preset1_n(dir[1]), .preset2_n(dir[0]), .j1(jk[3]), .k1(jk[2]),
    .j2(jk[1]), .k2(jk[0]), .q1(q1), .q1_n(q1_n), .q2(q2), .q2_n(q2_n)
  );

  ////////////////////////////////////////////////////////////////////////
  // compare all four outputs
  task automatic chk(input logic [3:0] exp);
    checks_done++;
    if ({q1, q1_n, q2, q2_n} !== exp)
    begin
      err_count++;
      $display("wrong value at %0t: exp %h got %h", $time, exp, {q1, q1_n, q2, q2_n});
    end
  endtask : chk

  // expected next state of one element from its j, k
  function automatic logic nx(input logic e, input logic [1:0] v);
    case (v)
      2'b00:   nx = e;
      2'b01:   nx = 1'b0;
      2'b10:   nx = 1'b1;
      default: nx = ~e;
    endcase
  endfunction : nx

  // one falling edge, then judge
  task automatic op(input logic [3:0] v, input logic late);
    drv.pulse(v, late);
    e1 = nx(e1, v[3:2]);
    e2 = nx(e2, v[1:0]);
    #1 chk({e1, ~e1, e2, ~e2});
  endtask : op

  ////////////////////////////////////////////////////////////////////////
  // all four jk codes on each element, elements differing
  task automatic t_table;
    op(4'h9, 1'b0);
    op(4'h3, 1'b0);
    op(4'hF, 1'b0);
    op(4'h6, 1'b0);
    op(4'h0, 1'b0);
    op(4'hF, 1'b1);
    op(4'h0, 1'b1);
  endtask : t_table

  // rising edge and jk changes between edges do nothing
  task automatic t_levels;
    drv.lvl(1'b1, 4'hF);
    repeat (3) @(posedge clk);
    #1 chk({e1, ~e1, e2, ~e2});
    drv.lvl(1'b1, 4'h0);
    drv.lvl(1'b0, 4'h0);
    drv.lvl(1'b0, 4'hF);
    repeat (3) @(posedge clk);
    #1 chk({e1, ~e1, e2, ~e2});
    drv.lvl(1'b0, 4'h0);
  endtask : t_levels

  // direct preset, clear, both, and clocking while forced
  task automatic t_direct;
    drv.set_dir(3'h5);
    #1 chk({1'b1, 1'b0, e2, ~e2});
    drv.set_dir(3'h1);
    #1 chk(4'hD);
    drv.pulse(4'hF, 1'b0);
    #1 chk(4'hD);
    drv.set_dir(3'h7);
    e1 = 1'b1;
    e2 = 1'b0;
    #1 chk(4'h9);
    op(4'hF, 1'b0);
    drv.set_dir(3'h3);
    #1 chk(4'h5);
    drv.set_dir(3'h7);
    e1 = 1'b0;
    e2 = 1'b0;
    // preset of element 1 alone leaves element 2 alone
    drv.set_dir(3'h5);
    #1 chk(4'h9);
    drv.set_dir(3'h7);
    #1 chk(4'h9);
    // both direct inputs low on element 2 as well
    drv.set_dir(3'h0);
    #1 chk(4'hF);
    drv.set_dir(3'h7);
    #1 chk(4'hA);
    e1 = 1'b1;
    e2 = 1'b1;
  endtask : t_direct

  // second reset mid-run
  task automatic t_rst;
    op(4'hA, 1'b0);
    @(posedge clk);
    nrst <= 1'b0;
    #1 chk(4'h5);
    @(posedge clk);
    nrst <= 1'b1;
    e1 = 1'b0;
    e2 = 1'b0;
  endtask : t_rst

  ////////////////////////////////////////////////////////////////////////
  // verdict and end of run
  task automatic results;
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
    begin
      $display("STATUS OK");
    end
    else
    begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : results

  // main sequence
  initial
  begin
    nrst        = 1'b0;
    err_count   = 0;
    checks_done = 0;
    e1          = 1'b0;
    e2          = 1'b0;
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    #1 chk(4'h5);
    t_table();
    t_levels();
    t_direct();
    t_rst();
    t_table();
    results();
  end
endmodule : djkff_top_test
